// ---- port_mux_pkg.sv ----
// Purpose: shared constants and carrier types for the port function multiplexer
// Assumes: 8-bit register bus with 4-bit register index
// Notes: reset values and field positions used by the mux logic
package port_mux_pkg;

    // ========================================
    // register index map
    localparam logic [3:0] ADDR_P2_DIR = 4'h0;
    localparam logic [3:0] ADDR_P2_DATA = 4'h1;
    localparam logic [3:0] ADDR_P2_CFG = 4'h2;
    localparam logic [3:0] ADDR_P3_MODE = 4'h3;
    localparam logic [3:0] ADDR_IRQ_EDGE = 4'h4;
    localparam logic [3:0] ADDR_PORT_CFG = 4'h5;
    localparam logic [3:0] ADDR_TC0 = 4'h6;
    localparam logic [3:0] ADDR_TC1 = 4'h7;
    localparam logic [3:0] ADDR_TC2 = 4'h8;
    localparam logic [3:0] ADDR_P3_DATA = 4'h9;
    localparam logic [3:0] ADDR_P2_IN = 4'hA;
    localparam logic [3:0] ADDR_P3_IN = 4'hB;

    // ========================================
    // reset values
    localparam logic [7:0] RST_P2_DIR = 8'hFF;
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_PORT_CFG = 8'h03;
    localparam logic [7:0] READ_NONE = 8'h00;

    // ========================================
    // field positions
    localparam int P2CFG_PUSH_PULL_BIT = 0;
    localparam int P2CFG_HS_BIT = 1;
    localparam int P3M_ANALOG_BIT = 1;
    localparam int P3M_P0HS_BIT = 2;
    localparam int P3M_P1HS_BIT = 3;
    localparam int P3M_DM_BIT = 4;
    localparam int IRQ_EDGE_LO_BIT = 6;
    localparam int IRQ_EDGE_HI_BIT = 7;
    localparam int PORT_CONFIGURATION_REGISTER_COMP1_OFF_BIT = 0;
    localparam int PORT_CONFIGURATION_REGISTER_COMP2_OFF_BIT = 1;
    localparam int TC0_T8_OUT_BIT = 0;
    localparam int TC2_T16_OUT_BIT = 0;
    localparam int TC1_EDGE_SRC_BIT = 2;
    localparam int TC1_SEL_LO_BIT = 4;
    localparam int TC1_SEL_HI_BIT = 5;
    localparam int P2_HS_DIR_BIT = 7;

    // ========================================
    // encodings
    localparam logic [1:0] TC1_SEL_NONE = 2'h0;
    localparam logic [1:0] TC1_SEL_T8 = 2'h1;
    localparam logic [1:0] TC1_SEL_T16 = 2'h2;
    localparam logic [1:0] EDGE_FALL = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;

    // ========================================
    // carriers
    typedef struct packed {
        logic t8;
        logic t16;
        logic logic_comb;
    } timer_out_t;

    typedef struct packed {
        logic p2;
        logic p1;
        logic p0;
    } hs_t;

    typedef struct packed {
        logic [7:0] p2;
        logic [3:1] p3;
        logic [1:0] comp;
    } pin_sample_t;

endpackage

// ---- line_select.sv ----
// Purpose: fixed-priority source selector for one port 3 output line
// Assumes: source 0 has the highest priority
// Notes: exactly one source reaches the line; the default when none is enabled
`timescale 1ns/1ps
`default_nettype none
module line_select #(
    parameter int N = 2
) (
    input wire logic [N-1:0] i_en,
    input wire logic [N-1:0] i_src,
    input wire logic i_default,
    output logic o_line
);

    // ========================================
    // priority chain; each stage falls through to the next lower priority
    logic [N:0] chain;

    assign chain[N] = i_default;

    // counts upwards so the loop variable never goes negative
    genvar g;
    generate
        for (g = 0; g < N; g++)
        begin : g_stage
            assign chain[g] = i_en[g] ? i_src[g] : chain[g + 1];
        end
    endgenerate

    assign o_line = chain[0];

endmodule
`default_nettype wire

// ---- port_function_mux.sv ----
// Purpose: port 2 configuration and port 3 line function multiplexer
// Assumes: pins and comparator outputs are asynchronous; core signals share i_sys_clk
// Notes: handshake timing and counter/timers live outside this block
//
// Summary of operation
// - In port 2 handshake, line1 and line6 carry data-available and ready.
// - Port 2 bit 7 direction picks which of those two lines is which.
// - One global bit makes all port 2 drivers push-pull or open-drain.
// - Reset leaves every port 2 bit an input with open-drain driver.
// - Port 2 inputs feed an 8-bit NOR and a NAND as wake sources.
// - Port 3 lines 1-3 are inputs, lines 4-7 push-pull outputs.
// - Port 3 mode bit 1 puts lines 1 and 2 into comparator mode.
// - Lines 1 and 2 interrupt on rising, falling or both edges, bits 6-7.
// - Line1 reaches the timer edge detector only in digital mode.
// - In analog mode the edge detector may take port2_line0 instead.
// - Comparator 1 output drives line4 when configuration bit D0 is 0.
// - A timer output selected on line4 beats the comparator output.
// - Port 3 carries handshake for ports 0, 1, 2 and three interrupt inputs.
// - Timer control bits route timer and logic outputs onto port 3.
// - In analog mode line3 latch, interrupt 1 and stop recovery are all off.
// - In digital mode line3 is input bit 3 and raises interrupt 1.
// - Both comparators power down in stop mode.
// - Lines 1-3 are stop recovery sources only while digital.
// - Configuration register puts comparator outputs on line4 and line7.
// - Line4 may carry the active-low data-memory select.
//
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module port_function_mux
    import port_mux_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic [7:0] i_port2_pin,
    output logic [7:0] o_port2_out,
    output logic [7:0] o_port2_oe,
    input wire logic [3:1] i_port3_pin,
    output logic [7:4] o_port3_out,
    input wire logic [1:0] i_comp_out,
    output logic [1:0] o_comp_power_en,
    input wire logic i_stop_mode,
    input wire logic i_data_access,
    input wire timer_out_t i_timer_out,
    input wire hs_t i_hs_out,
    output hs_t o_hs_in,
    output logic o_port2_line1_is_dav,
    output logic [2:0] o_irq,
    output logic o_edge_detect_in,
    output logic o_wake_nor,
    output logic o_wake_nand,
    output logic [3:1] o_stop_recovery_sources
);

    // ========================================
    // register file
    logic [7:0] p2_dir_r;
    logic [7:0] p2_data_r;
    logic [7:0] p2_cfg_r;
    logic [7:0] p3_mode_r;
    logic [7:0] irq_edge_r;
    logic [7:0] port_configuration_register_r;
    logic [7:0] timer_control_0_r;
    logic [7:0] timer_control_1_r;
    logic [7:0] timer_control_2_r;
    logic [7:0] p3_data_r;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;

    // port 2 all inputs, open-drain after reset
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            p2_dir_r <= RST_P2_DIR;
            p2_data_r <= RST_ZERO;
            p2_cfg_r <= RST_ZERO;
            p3_mode_r <= RST_ZERO;
            irq_edge_r <= RST_ZERO;
            port_configuration_register_r <= RST_PORT_CFG;
            timer_control_0_r <= RST_ZERO;
            timer_control_1_r <= RST_ZERO;
            timer_control_2_r <= RST_ZERO;
            p3_data_r <= RST_ZERO;
        end
        else if (i_wr)
        begin
            case (i_addr)
                ADDR_P2_DIR: p2_dir_r <= i_wdata;
                ADDR_P2_DATA: p2_data_r <= i_wdata;
                ADDR_P2_CFG: p2_cfg_r <= i_wdata;
                ADDR_P3_MODE: p3_mode_r <= i_wdata;
                ADDR_IRQ_EDGE: irq_edge_r <= i_wdata;
                ADDR_PORT_CFG: port_configuration_register_r <= i_wdata;
                ADDR_TC0: timer_control_0_r <= i_wdata;
                ADDR_TC1: timer_control_1_r <= i_wdata;
                ADDR_TC2: timer_control_2_r <= i_wdata;
                ADDR_P3_DATA: p3_data_r <= i_wdata;
                default: ;
            endcase
        end
    end

    // ========================================
    // pin synchronisers; stage one feeds stage two only
    pin_sample_t sync1_r;
    pin_sample_t sync2_r;
    pin_sample_t prev_r;
    pin_sample_t pin_now;

    assign pin_now = '{p2: i_port2_pin, p3: i_port3_pin, comp: i_comp_out};

    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            sync1_r <= '1;
            sync2_r <= '1;
            prev_r <= '1;
        end
        else
        begin
            sync1_r <= pin_now;
            sync2_r <= sync1_r;
            prev_r <= sync2_r;
        end
    end

    // ========================================
    // mode decode
    logic analog;
    logic [1:0] comp_val;
    logic [1:0] comp_prev;
    logic [1:0] edge_mode;

    assign analog = p3_mode_r[P3M_ANALOG_BIT];
    assign o_comp_power_en = {2{analog & ~i_stop_mode}};
    // powered-down comparators read low so stale levels never reach the pins
    assign comp_val = sync2_r.comp & o_comp_power_en;
    assign comp_prev = prev_r.comp & o_comp_power_en;
    assign edge_mode = {irq_edge_r[IRQ_EDGE_HI_BIT], irq_edge_r[IRQ_EDGE_LO_BIT]};

    // ========================================
    // port 2 drivers and wake gates
    logic push_pull;

    assign push_pull = p2_cfg_r[P2CFG_PUSH_PULL_BIT];
    assign o_port2_out = p2_data_r;

    // open-drain only drives the low level; a set dir bit means input
    genvar b;
    generate
        for (b = 0; b < 8; b++)
        begin : g_p2_oe
            assign o_port2_oe[b] = ~p2_dir_r[b] & (push_pull | ~p2_data_r[b]);
        end
    endgenerate

    assign o_wake_nor = ~|sync2_r.p2;
    assign o_wake_nand = ~&sync2_r.p2;

    // ========================================
    // interrupt edge detection
    logic [3:1] src_now;
    logic [3:1] src_prev;
    logic [3:1] rise;
    logic [3:1] fall;
    logic [2:1] hit12;
    logic [2:0] irq_nxt;
    logic [2:0] irq_r;

    // lines 1 and 2 follow the comparators in analog mode
    assign src_now = {sync2_r.p3[3], analog ? comp_val : sync2_r.p3[2:1]};
    assign src_prev = {prev_r.p3[3], analog ? comp_prev : prev_r.p3[2:1]};
    assign rise = src_now & ~src_prev;
    assign fall = ~src_now & src_prev;

    always_comb
    begin
        case (edge_mode)
            EDGE_FALL: hit12 = fall[2:1];
            EDGE_RISE: hit12 = rise[2:1];
            default: hit12 = rise[2:1] | fall[2:1];
        endcase
        // line1 raises irq2, line2 irq0, line3 irq1
        irq_nxt = {hit12[1], fall[3] & ~analog, hit12[2]};
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            irq_r <= RST_ZERO[2:0];
        else
            irq_r <= irq_nxt;
    end

    assign o_irq = irq_r;

    // ========================================
    // timer edge detection source
    logic edge_src_p20;
    logic edge_nxt;
    logic edge_r;

    assign edge_src_p20 = timer_control_1_r[TC1_EDGE_SRC_BIT];

    always_comb
    begin
        if (edge_src_p20)
            edge_nxt = sync2_r.p2[0];
        else if (!analog)
            edge_nxt = sync2_r.p3[1];
        else
            edge_nxt = 1'b0;
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            edge_r <= 1'b0;
        else
            edge_r <= edge_nxt;
    end

    assign o_edge_detect_in = edge_r;

    // ========================================
    // stop recovery and handshake inputs
    // lines idle high when analog so a handshake never sees a false strobe
    assign o_stop_recovery_sources = analog ? 3'h0 : sync2_r.p3;
    assign o_hs_in = '{p2: analog | sync2_r.p3[1], p1: analog | sync2_r.p3[3], p0: analog | sync2_r.p3[2]};
    assign o_port2_line1_is_dav = p2_dir_r[P2_HS_DIR_BIT];

    // ========================================
    // port 3 output priority
    logic [1:0] tc1_sel;
    logic line6_timer;
    logic [3:0] en4;
    logic [3:0] src4;
    logic [1:0] en5;
    logic [1:0] src5;
    logic [1:0] en6;
    logic [1:0] src6;
    logic line4;
    logic line5;
    logic line6;
    logic line7;
    logic [7:4] p3_out_r;

    assign tc1_sel = {timer_control_1_r[TC1_SEL_HI_BIT], timer_control_1_r[TC1_SEL_LO_BIT]};

    always_comb
    begin
        case (tc1_sel)
            TC1_SEL_T8: line6_timer = i_timer_out.t8;
            TC1_SEL_T16: line6_timer = i_timer_out.t16;
            default: line6_timer = i_timer_out.logic_comb;
        endcase
    end

    // line4: timer, comparator 1, data memory select, port 1 handshake
    assign en4 = {p3_mode_r[P3M_P1HS_BIT], p3_mode_r[P3M_DM_BIT],
                  ~port_configuration_register_r[PORT_CONFIGURATION_REGISTER_COMP1_OFF_BIT], timer_control_0_r[TC0_T8_OUT_BIT]};
    assign src4 = {i_hs_out.p1, ~i_data_access, comp_val[0], i_timer_out.t8};

    line_select #(.N(4)) u_line4 (
        .i_en(en4),
        .i_src(src4),
        .i_default(p3_data_r[4]),
        .o_line(line4)
    );

    // line5: 16-bit timer, port 0 handshake
    assign en5 = {p3_mode_r[P3M_P0HS_BIT], timer_control_2_r[TC2_T16_OUT_BIT]};
    assign src5 = {i_hs_out.p0, i_timer_out.t16};

    line_select #(.N(2)) u_line5 (
        .i_en(en5),
        .i_src(src5),
        .i_default(p3_data_r[5]),
        .o_line(line5)
    );

    // line6: timer or logic combination, port 2 handshake
    assign en6 = {p2_cfg_r[P2CFG_HS_BIT], tc1_sel != TC1_SEL_NONE};
    assign src6 = {i_hs_out.p2, line6_timer};

    line_select #(.N(2)) u_line6 (
        .i_en(en6),
        .i_src(src6),
        .i_default(p3_data_r[6]),
        .o_line(line6)
    );

    // line7: comparator 2 only
    line_select #(.N(1)) u_line7 (
        .i_en(~port_configuration_register_r[PORT_CONFIGURATION_REGISTER_COMP2_OFF_BIT]),
        .i_src(comp_val[1]),
        .i_default(p3_data_r[7]),
        .o_line(line7)
    );

    // registered so that the pins never glitch between sources
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            p3_out_r <= RST_ZERO[7:4];
        else
            p3_out_r <= {line7, line6, line5, line4};
    end

    assign o_port3_out = p3_out_r;

    // ========================================
    // register read path
    logic [7:0] p3_in_view;

    // line3 drops out of the input register in analog mode
    assign p3_in_view = {4'h0, sync2_r.p3[3] & ~analog, analog ? comp_val : sync2_r.p3[2:1], 1'b0};

    always_comb
    begin
        rdata_nxt = READ_NONE;
        if (i_rd)
        begin
            case (i_addr)
                ADDR_P2_DIR: rdata_nxt = p2_dir_r;
                ADDR_P2_DATA: rdata_nxt = p2_data_r;
                ADDR_P2_CFG: rdata_nxt = p2_cfg_r;
                ADDR_P3_MODE: rdata_nxt = p3_mode_r;
                ADDR_IRQ_EDGE: rdata_nxt = irq_edge_r;
                ADDR_PORT_CFG: rdata_nxt = port_configuration_register_r;
                ADDR_TC0: rdata_nxt = timer_control_0_r;
                ADDR_TC1: rdata_nxt = timer_control_1_r;
                ADDR_TC2: rdata_nxt = timer_control_2_r;
                ADDR_P3_DATA: rdata_nxt = p3_data_r;
                ADDR_P2_IN: rdata_nxt = sync2_r.p2;
                ADDR_P3_IN: rdata_nxt = p3_in_view;
                default: rdata_nxt = READ_NONE;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            rdata_r <= READ_NONE;
        else
            rdata_r <= rdata_nxt;
    end

    assign o_rdata = rdata_r;

endmodule
`default_nettype wire

// ---- port_mux_assertions.sv ----
// Purpose: port checks for port_function_mux
// Assumes: one clock, async low reset
// Notes: pin history checks wait until the synchronisers are full
`timescale 1ns/1ps
`default_nettype none
module port_mux_assertions
    import port_mux_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_nrst,
    input wire logic [7:0] i_port2_pin,
    input wire logic [3:1] i_port3_pin,
    input wire logic i_stop_mode,
    input wire logic [1:0] o_comp_power_en,
    input wire hs_t o_hs_in,
    input wire logic [2:0] o_irq,
    input wire logic o_wake_nor,
    input wire logic o_wake_nand,
    input wire logic [3:1] o_stop_recovery_sources
);
    // ========================================
    // helpers: history before this count still holds reset values
    logic [2:0] up_r;
    logic ana, dig, ok;
    assign ana = o_comp_power_en[0];
    assign dig = !ana && !i_stop_mode;
    assign ok = (up_r == 3'h5);
    always_ff @(posedge i_sys_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            up_r <= 3'h0;
        else if (!ok)
            up_r <= up_r + 3'h1;
    end
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_nrst);
    // ========================================
    // assertions
    AST_STOP_PWR: assert property (i_stop_mode |-> o_comp_power_en == 2'h0)
        else $error("comparators powered in stop mode");
    AST_SRC_ANA: assert property (ana |-> o_stop_recovery_sources == 3'h0)
        else $error("stop sources active in analog mode");
    AST_SRC_DIG: assert property ((ok && dig) |-> o_stop_recovery_sources == $past(i_port3_pin, 2))
        else $error("stop sources do not follow pins");
    AST_HS_ANA: assert property (ana |-> o_hs_in == 3'h7)
        else $error("handshake inputs not parked in analog mode");
    AST_NOR: assert property (ok |-> o_wake_nor == ~|$past(i_port2_pin, 2))
        else $error("wake nor wrong");
    AST_NAND: assert property (ok |-> o_wake_nand == ~&$past(i_port2_pin, 2))
        else $error("wake nand wrong");
    AST_IRQ1: assert property ((ok && o_irq[1]) |-> !$past(i_port3_pin[3], 3) && $past(i_port3_pin[3], 4))
        else $error("line3 interrupt without falling edge");
    AST_IRQ2: assert property ((ok && o_irq[2] && dig && $past(dig) && $past(dig, 2))
        |-> $past(i_port3_pin[1], 3) != $past(i_port3_pin[1], 4))
        else $error("line1 interrupt without edge");
    COV_IRQ1: cover property (o_irq[1]);
    COV_IRQ02: cover property (o_irq[2] && o_irq[0]);
    COV_ANA: cover property (ana);
endmodule
bind port_function_mux port_mux_assertions u_chk (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_port2_pin(i_port2_pin),
    .i_port3_pin(i_port3_pin),
    .i_stop_mode(i_stop_mode),
    .o_comp_power_en(o_comp_power_en),
    .o_hs_in(o_hs_in),
    .o_irq(o_irq),
    .o_wake_nor(o_wake_nor),
    .o_wake_nand(o_wake_nand),
    .o_stop_recovery_sources(o_stop_recovery_sources)
);
`default_nettype wire

// ---- pin_world.sv ----
// Purpose: far-side model of the port 2 pins
// Assumes: undriven pins follow the external level
// Notes: optional strap loops port 3 line 4 into port 2 line 0
`timescale 1ns/1ps
`default_nettype none
module pin_world (
    input wire logic [7:0] i_oe,
    input wire logic [7:0] i_out,
    input wire logic [7:0] i_ext,
    input wire logic i_loop,
    input wire logic i_line4,
    output logic [7:0] o_pin
);
    // ========================================
    // resolution: the chip wins where it drives, except line 0 while the strap is on
    always_comb
    begin
        o_pin = (i_oe & i_out) | (~i_oe & i_ext);
        if (i_loop)
            o_pin[0] = i_line4;
    end
endmodule
`default_nettype wire

// ---- test_port_function_mux.sv ----
// Purpose: directed test of port_function_mux
// Assumes: pins reach outputs within four edges
// Notes: registers reached through the one-cycle strobe port
`timescale 1ns/1ps
`default_nettype none
module test_port_function_mux;
    import port_mux_pkg::*;
    logic clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, ext = 8'hFF, rdata, p2_out, p2_oe, p2_pin;
    logic [3:1] p3_pin = 3'h7, srcs;
    logic [7:4] p3_out;
    logic [1:0] comp = 2'h0, pwr;
    logic stop = 1'b0, dacc = 1'b0, loop = 1'b0, is_dav, edge_in, nor_w, nand_w;
    logic [2:0] irq;
    timer_out_t tmr = 3'h0;
    hs_t hs_out = 3'h0, hs_in;
    logic [7:0] emode [3] = '{8'h40, 8'h00, 8'h80};
    logic [7:0] erise [3] = '{8'h01, 8'h00, 8'h01};
    logic [7:0] efall [3] = '{8'h00, 8'h01, 8'h01};
    int miscompares = 0, samples_checked = 0;
    port_function_mux DUT (.i_sys_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_port2_pin(p2_pin), .o_port2_out(p2_out),
        .o_port2_oe(p2_oe), .i_port3_pin(p3_pin), .o_port3_out(p3_out), .i_comp_out(comp),
        .o_comp_power_en(pwr), .i_stop_mode(stop), .i_data_access(dacc), .i_timer_out(tmr),
        .i_hs_out(hs_out), .o_hs_in(hs_in), .o_port2_line1_is_dav(is_dav), .o_irq(irq),
        .o_edge_detect_in(edge_in), .o_wake_nor(nor_w), .o_wake_nand(nand_w),
        .o_stop_recovery_sources(srcs));
    pin_world u_pins (.i_oe(p2_oe), .i_out(p2_out), .i_ext(ext), .i_loop(loop),
        .i_line4(p3_out[4]), .o_pin(p2_pin));
    // ========================================
    // clock, tasks
    initial
    begin
        forever #25 clk = ~clk;
    end
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("rdata", exp, rdata);
    endtask
    task automatic settle();
        repeat (4) @(posedge clk);
        #1;
    endtask
    // pulses are one cycle long, so counting cycles counts events
    task automatic irq_count(input logic [2:0] m, input logic [7:0] exp);
        int n;
        n = 0;
        repeat (8)
        begin
            @(posedge clk);
            #1;
            if ((irq & m) === m)
                n++;
        end
        chk("irq", exp, 8'(n));
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        #400000;
        miscompares++;
        finish_test();
    end
    // ========================================
    // main sequence
    initial
    begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        #1;
        chk("oe", 8'h00, p2_oe);
        rd_reg(ADDR_P2_DIR, RST_P2_DIR);
        rd_reg(ADDR_P2_CFG, RST_ZERO);
        rd_reg(ADDR_PORT_CFG, RST_PORT_CFG);
        rd_reg(4'hC, READ_NONE);
        wr_reg(ADDR_P2_DIR, 8'h00);
        wr_reg(ADDR_P2_DATA, 8'h0F);
        settle();
        chk("oe", 8'hF0, p2_oe);
        chk("p2out", 8'h0F, p2_out);
        chk("nand", 8'h01, 8'(nand_w));
        wr_reg(ADDR_P2_CFG, 8'h01);
        settle();
        chk("oe", 8'hFF, p2_oe);
        wr_reg(ADDR_P2_DIR, 8'h7F);
        ext <= 8'h00;
        settle();
        chk("nor", 8'h01, 8'(nor_w));
        chk("dav", 8'h00, 8'(is_dav));
        wr_reg(ADDR_P2_DIR, 8'hFF);
        ext <= 8'hFF;
        settle();
        chk("nand", 8'h00, 8'(nand_w));
        chk("dav", 8'h01, 8'(is_dav));
        wr_reg(ADDR_P2_CFG, 8'h02);
        hs_out <= 3'h4;
        settle();
        chk("line6", 8'h01, 8'(p3_out[6]));
        wr_reg(ADDR_TC1, 8'h30);
        hs_out <= 3'h0;
        tmr <= 3'h1;
        settle();
        chk("line6", 8'h01, 8'(p3_out[6]));
        wr_reg(ADDR_TC2, 8'h01);
        tmr <= 3'h2;
        settle();
        chk("p3out", 8'h02, 8'(p3_out));
        wr_reg(ADDR_P3_MODE, 8'h10);
        settle();
        chk("line4", 8'h01, 8'(p3_out[4]));
        wr_reg(ADDR_PORT_CFG, 8'h00);
        wr_reg(ADDR_P3_MODE, 8'h12);
        dacc <= 1'b1;
        comp <= 2'h3;
        settle();
        chk("p3out", 8'h0B, 8'(p3_out));
        chk("pwr", 8'h03, 8'(pwr));
        wr_reg(ADDR_TC0, 8'h01);
        settle();
        chk("line4", 8'h00, 8'(p3_out[4]));
        wr_reg(ADDR_TC0, 8'h00);
        ext <= 8'h00;
        settle();
        chk("edge", 8'h00, 8'(edge_in));
        wr_reg(ADDR_TC1, 8'h34);
        loop <= 1'b1;
        settle();
        chk("edge", 8'h01, 8'(edge_in));
        @(posedge clk);
        p3_pin[3] <= 1'b0;
        irq_count(3'h2, 8'h00);
        rd_reg(ADDR_P3_IN, 8'h06);
        chk("srcs", 8'h00, 8'(srcs));
        @(posedge clk);
        stop <= 1'b1;
        settle();
        chk("pwr", 8'h00, 8'(pwr));
        wr_reg(ADDR_P3_MODE, 8'h00);
        stop <= 1'b0;
        loop <= 1'b0;
        p3_pin <= 3'h4;
        wr_reg(ADDR_TC1, 8'h00);
        settle();
        foreach (emode[i])
        begin
            wr_reg(ADDR_IRQ_EDGE, emode[i]);
            p3_pin[2:1] <= 2'h3;
            irq_count(3'h5, erise[i]);
            @(posedge clk);
            p3_pin[2:1] <= 2'h0;
            irq_count(3'h5, efall[i]);
        end
        chk("hsin", 8'h02, 8'(hs_in));
        @(posedge clk);
        p3_pin[3] <= 1'b0;
        irq_count(3'h2, 8'h01);
        rd_reg(ADDR_P3_IN, 8'h00);
        @(posedge clk);
        p3_pin[1] <= 1'b1;
        settle();
        chk("edge", 8'h01, 8'(edge_in));
        chk("srcs", 8'h01, 8'(srcs));
        finish_test();
    end
endmodule
`default_nettype wire
